// ### rtl/dmsd_pkg.sv
// Operation
// - no saturation: overflowed sum wraps in accumulator
// - saturation: overflow clamps to most positive/negative
// - set/clear/status-load instructions write saturation bit
// - product shift mode 00 passes product unshifted
// - mode 01 shifts product left one, zero fill
// - mode 10 shifts product left four, zero fill
// - mode 11 shifts product right six, sign fill
// - shift affects output path, not stored product
// - product mode set by instructions, reset to zero
// - sign-extension bit selects sign or zero upper fill
// - suppressed-extension add always zero fills upper bits
// - sign-extension bit set/clear/loaded, reset to one
// - test flag set by bit-test, compare, normalize
// - conditional decisions follow the test flag
// - external flag drives pin, set/clear, reset one
// - scaler maps 16-bit operand to 32 bits combinationally
// - scaler shifts left 0 to 16, zero low fill
// - shift count from instruction or operand register
// - multiplier forms 32-bit product in one cycle
// - multiplies signed except the unsigned multiply
// - 16-bit operand register, 32-bit product register
`default_nettype none
package dmsd_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_OPERAND = 8'h04;
   localparam logic [7:0] OFS_CMD = 8'h08;
   localparam logic [7:0] OFS_MULT_OP = 8'h0c;
   localparam logic [7:0] OFS_PROD_RAW = 8'h10;
   localparam logic [7:0] OFS_PROD_SHIFTED = 8'h14;
   localparam logic [7:0] OFS_ACC = 8'h18;
   localparam logic [7:0] OFS_SCALED = 8'h1c;
   localparam logic [7:0] OFS_AUX = 8'h20;
   localparam logic [7:0] OFS_DECISION = 8'h24;

   // status word field positions
   localparam int POS_PM = 0;
   localparam int POS_XF = 4;
   localparam int POS_SXM = 10;
   localparam int POS_TC = 11;
   localparam int POS_SAT = 12;
   localparam int POS_OVF = 13;

   // command word field positions
   localparam int POS_OPCODE = 0;
   localparam int POS_ARG = 4;

   // values after reset
   localparam logic [1:0] RST_PM = 2'h0;
   localparam logic RST_SXM = 1'b1;
   localparam logic RST_XF = 1'b1;
   localparam logic RST_SAT = 1'b0;
   localparam logic RST_TC = 1'b0;

   // datapath constants
   localparam logic [4:0] MAX_SHIFT = 5'h10;
   localparam logic [31:0] SAT_POS = 32'h7fffffff;
   localparam logic [31:0] SAT_NEG = 32'h80000000;

   // flag selectors for set/clear instructions
   localparam logic [1:0] FLG_SAT = 2'h0;
   localparam logic [1:0] FLG_SXM = 2'h1;
   localparam logic [1:0] FLG_TC = 2'h2;
   localparam logic [1:0] FLG_XF = 2'h3;

   // auxiliary compare conditions
   localparam logic [1:0] CMP_EQ = 2'h0;
   localparam logic [1:0] CMP_LT = 2'h1;
   localparam logic [1:0] CMP_GT = 2'h2;
   localparam logic [1:0] CMP_NE = 2'h3;

   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_SET_FLAG = 4'h1,
      OP_CLR_FLAG = 4'h2,
      OP_SET_PM = 4'h3,
      OP_LOAD_MULT = 4'h4,
      OP_MPY = 4'h5,
      OP_UNSIGNED_MULTIPLY_INSTRUCTION = 4'h6,
      OP_ADD_SHIFT = 4'h7,
      OP_ADD_NOEXT = 4'h8,
      OP_ADD_BY_MULT = 4'h9,
      OP_ADD_PROD = 4'ha,
      OP_BIT_TEST = 4'hb,
      OP_AUX_CMP = 4'hc,
      OP_NORMALIZE = 4'hd,
      OP_COND = 4'he
   } dmsd_op_e;
endpackage
`default_nettype wire

// ### rtl/dmsd_shift_if.sv
`default_nettype none
// carries operands to the shifter and its results back, all combinational
interface dmsd_shift_if;
   logic [15:0] operand;
   logic [4:0] count;
   logic sext;
   logic [31:0] product_register;
   logic [1:0] pm;
   logic [31:0] scaled;
   logic [31:0] pscaled;
   modport core (output operand, count, sext, product_register, pm, input scaled, pscaled);
   modport shifter (input operand, count, sext, product_register, pm, output scaled, pscaled);
endinterface
`default_nettype wire

// ### rtl/dmsd_shifter.sv
`default_nettype none
module dmsd_shifter (
   // link to the core
   dmsd_shift_if.shifter sh
);
   logic [31:0] ext_w;
   logic [4:0] cnt_w;

   // upper half fill chosen by the effective sign mode
   assign ext_w = {{16{sh.sext & sh.operand[15]}}, sh.operand};
   // counts above the top are held at sixteen
   assign cnt_w = (sh.count > dmsd_pkg::MAX_SHIFT) ? dmsd_pkg::MAX_SHIFT : sh.count;
   // pure logic, so the scaled word reaches the adder in the same cycle
   assign sh.scaled = ext_w << cnt_w;

   // product output shifter; it only reads the product, never writes it back
   always_comb begin
      case (sh.pm)
         2'h0: sh.pscaled = sh.product_register;
         2'h1: sh.pscaled = {sh.product_register[30:0], 1'b0};
         2'h2: sh.pscaled = {sh.product_register[27:0], 4'h0};
         2'h3: sh.pscaled = {{6{sh.product_register[31]}}, sh.product_register[31:6]};
         default: sh.pscaled = sh.product_register;
      endcase
   end
endmodule
`default_nettype wire

// ### rtl/dmsd_top.sv
// Chosen here: the placing of the registers and the APB interface to the registers.
`default_nettype none
module dmsd_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // flags toward the rest of the core and the pin
   output logic xf_o,
   output logic test_flag_o
);
   // saturating or wrapping add; returns {overflow, result}
   function automatic logic [32:0] sat_add(input logic [31:0] a, input logic [31:0] b,
                                           input logic sat);
      logic [31:0] s;
      logic ovf;
      s = a + b;
      ovf = (a[31] == b[31]) && (s[31] != a[31]);
      if (ovf && sat) begin
         s = a[31] ? dmsd_pkg::SAT_NEG : dmsd_pkg::SAT_POS;
      end
      return {ovf, s};
   endfunction

   // address decode, shared by write enable and error answer
   function automatic logic addr_hit(input logic [7:0] a);
      case (a)
         dmsd_pkg::OFS_STATUS, dmsd_pkg::OFS_OPERAND, dmsd_pkg::OFS_CMD,
         dmsd_pkg::OFS_MULT_OP, dmsd_pkg::OFS_PROD_RAW, dmsd_pkg::OFS_PROD_SHIFTED,
         dmsd_pkg::OFS_ACC, dmsd_pkg::OFS_SCALED, dmsd_pkg::OFS_AUX,
         dmsd_pkg::OFS_DECISION: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   endfunction

   logic [1:0] rst_sync_r;
   logic rstn;
   logic pready_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic [31:0] rd_data;
   logic commit;
   logic wr;
   logic sat_r;
   logic sxm_r;
   logic xf_r;
   logic tc_r;
   logic ovf_r;
   logic decision_r;
   logic [1:0] pm_r;
   logic [15:0] operand_r;
   logic [15:0] mult_op_r;
   logic [31:0] product_register_r;
   logic [31:0] acc_r;
   logic [15:0] aux_sel_r;
   logic [15:0] aux_zero_r;
   logic [31:0] status_w;
   logic cmd_go;
   logic stat_go;
   dmsd_pkg::dmsd_op_e op;
   logic [4:0] arg;
   logic acc_add;
   logic [31:0] acc_rhs;
   logic [32:0] sum_w;
   logic [31:0] product_w;
   logic mul_sgn;
   logic [31:0] mul_a;
   logic [31:0] mul_b;
   logic tc_hit;
   logic tc_touch;

   dmsd_shift_if sh ();

   // reset released through two flops; assertion stays asynchronous
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rstn = rst_sync_r[1];

   // apb: one wait state, answer registered so outputs come from flops
   assign commit = psel_i & penable_i & pready_r;
   assign wr = commit & pwrite_i & addr_hit(paddr_i);

   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         pready_r <= psel_i & penable_i & ~pready_r;
         if (psel_i & penable_i & ~pready_r) begin
            pslverr_r <= ~addr_hit(paddr_i);
            prdata_r <= pwrite_i ? 32'h0 : rd_data;
         end else begin
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
         end
      end
   end

   // status word image, unused bits read as zero
   always_comb begin
      status_w = 32'h0;
      status_w[dmsd_pkg::POS_PM +: 2] = pm_r;
      status_w[dmsd_pkg::POS_XF] = xf_r;
      status_w[dmsd_pkg::POS_SXM] = sxm_r;
      status_w[dmsd_pkg::POS_TC] = tc_r;
      status_w[dmsd_pkg::POS_SAT] = sat_r;
      status_w[dmsd_pkg::POS_OVF] = ovf_r;
   end

   // read mux; unmapped addresses read zero and also flag an error
   always_comb begin
      case (paddr_i)
         dmsd_pkg::OFS_STATUS: rd_data = status_w;
         dmsd_pkg::OFS_OPERAND: rd_data = {16'h0, operand_r};
         dmsd_pkg::OFS_MULT_OP: rd_data = {16'h0, mult_op_r};
         dmsd_pkg::OFS_PROD_RAW: rd_data = product_register_r;
         dmsd_pkg::OFS_PROD_SHIFTED: rd_data = sh.pscaled;
         dmsd_pkg::OFS_ACC: rd_data = acc_r;
         dmsd_pkg::OFS_SCALED: rd_data = sh.scaled;
         dmsd_pkg::OFS_AUX: rd_data = {aux_zero_r, aux_sel_r};
         dmsd_pkg::OFS_DECISION: rd_data = {31'h0, decision_r};
         default: rd_data = 32'h0;
      endcase
   end

   // command decode; a command executes on the completing write edge
   assign cmd_go = wr && (paddr_i == dmsd_pkg::OFS_CMD);
   assign stat_go = wr && (paddr_i == dmsd_pkg::OFS_STATUS);
   assign op = dmsd_pkg::dmsd_op_e'(pwdata_i[dmsd_pkg::POS_OPCODE +: 4]);
   assign arg = pwdata_i[dmsd_pkg::POS_ARG +: 5];

   // shifter inputs: count from the instruction or from the operand register
   assign sh.operand = operand_r;
   assign sh.count = (cmd_go && op == dmsd_pkg::OP_ADD_BY_MULT) ?
                     {1'b0, mult_op_r[3:0]} : arg;
   assign sh.sext = sxm_r & ~(cmd_go && op == dmsd_pkg::OP_ADD_NOEXT);
   assign sh.product_register = product_register_r;
   assign sh.pm = pm_r;

   dmsd_shifter u_shifter (
      .sh(sh)
   );

   // multiplier: operands widened to 32 bits with sign or zero fill, so the low word
   // of one product serves both kinds without a second multiplier
   assign mul_sgn = (op != dmsd_pkg::OP_UNSIGNED_MULTIPLY_INSTRUCTION);
   assign mul_a = {{16{mul_sgn & mult_op_r[15]}}, mult_op_r};
   assign mul_b = {{16{mul_sgn & operand_r[15]}}, operand_r};
   assign product_w = mul_a * mul_b;

   // accumulator input select and saturating add
   always_comb begin
      acc_add = 1'b0;
      acc_rhs = 32'h0;
      if (cmd_go) begin
         case (op)
            dmsd_pkg::OP_ADD_SHIFT, dmsd_pkg::OP_ADD_NOEXT, dmsd_pkg::OP_ADD_BY_MULT: begin
               acc_add = 1'b1;
               acc_rhs = sh.scaled;
            end
            dmsd_pkg::OP_ADD_PROD: begin
               acc_add = 1'b1;
               acc_rhs = sh.pscaled;
            end
            default: begin
               acc_add = 1'b0;
               acc_rhs = 32'h0;
            end
         endcase
      end
   end
   assign sum_w = sat_add(acc_r, acc_rhs, sat_r);

   // accumulator: software load, add, or one normalize step
   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         acc_r <= 32'h0;
      end else if (wr && paddr_i == dmsd_pkg::OFS_ACC) begin
         acc_r <= pwdata_i;
      end else if (acc_add) begin
         acc_r <= sum_w[31:0];
      end else if (cmd_go && op == dmsd_pkg::OP_NORMALIZE && !(acc_r[31] ^ acc_r[30])) begin
         acc_r <= {acc_r[30:0], 1'b0};
      end
   end

   // sticky overflow, cleared only through a status load
   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         ovf_r <= 1'b0;
      end else if (acc_add && sum_w[32]) begin
         ovf_r <= 1'b1;
      end else if (stat_go) begin
         ovf_r <= pwdata_i[dmsd_pkg::POS_OVF];
      end
   end

   // saturation mode bit
   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         sat_r <= dmsd_pkg::RST_SAT;
      end else if (stat_go) begin
         sat_r <= pwdata_i[dmsd_pkg::POS_SAT];
      end else if (cmd_go && arg[1:0] == dmsd_pkg::FLG_SAT) begin
         if (op == dmsd_pkg::OP_SET_FLAG) begin
            sat_r <= 1'b1;
         end else if (op == dmsd_pkg::OP_CLR_FLAG) begin
            sat_r <= 1'b0;
         end
      end
   end

   // sign-extension mode bit, set after reset
   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         sxm_r <= dmsd_pkg::RST_SXM;
      end else if (stat_go) begin
         sxm_r <= pwdata_i[dmsd_pkg::POS_SXM];
      end else if (cmd_go && arg[1:0] == dmsd_pkg::FLG_SXM) begin
         if (op == dmsd_pkg::OP_SET_FLAG) begin
            sxm_r <= 1'b1;
         end else if (op == dmsd_pkg::OP_CLR_FLAG) begin
            sxm_r <= 1'b0;
         end
      end
   end

   // external flag bit, set after reset; drives the pin
   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         xf_r <= dmsd_pkg::RST_XF;
      end else if (stat_go) begin
         xf_r <= pwdata_i[dmsd_pkg::POS_XF];
      end else if (cmd_go && arg[1:0] == dmsd_pkg::FLG_XF) begin
         if (op == dmsd_pkg::OP_SET_FLAG) begin
            xf_r <= 1'b1;
         end else if (op == dmsd_pkg::OP_CLR_FLAG) begin
            xf_r <= 1'b0;
         end
      end
   end

   // product shift mode, cleared by reset
   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         pm_r <= dmsd_pkg::RST_PM;
      end else if (stat_go) begin
         pm_r <= pwdata_i[dmsd_pkg::POS_PM +: 2];
      end else if (cmd_go && op == dmsd_pkg::OP_SET_PM) begin
         pm_r <= arg[1:0];
      end
   end

   // test flag condition for the three instructions that evaluate it
   always_comb begin
      tc_touch = 1'b0;
      tc_hit = 1'b0;
      if (cmd_go) begin
         case (op)
            dmsd_pkg::OP_BIT_TEST: begin
               tc_touch = 1'b1;
               tc_hit = operand_r[4'hf - mult_op_r[3:0]]; // bit 0 of the count is the msb
            end
            dmsd_pkg::OP_AUX_CMP: begin
               tc_touch = 1'b1;
               case (arg[1:0])
                  dmsd_pkg::CMP_EQ: tc_hit = (aux_sel_r == aux_zero_r);
                  dmsd_pkg::CMP_LT: tc_hit = (aux_sel_r < aux_zero_r);
                  dmsd_pkg::CMP_GT: tc_hit = (aux_sel_r > aux_zero_r);
                  dmsd_pkg::CMP_NE: tc_hit = (aux_sel_r != aux_zero_r);
                  default: tc_hit = 1'b0;
               endcase
            end
            dmsd_pkg::OP_NORMALIZE: begin
               tc_touch = 1'b1;
               tc_hit = acc_r[31] ^ acc_r[30];
            end
            default: begin
               tc_touch = 1'b0;
               tc_hit = 1'b0;
            end
         endcase
      end
   end

   // test flag; only one apb write lands per edge, so updates never collide
   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         tc_r <= dmsd_pkg::RST_TC;
      end else if (stat_go) begin
         tc_r <= pwdata_i[dmsd_pkg::POS_TC];
      end else if (tc_touch) begin
         tc_r <= tc_hit;
      end else if (cmd_go && arg[1:0] == dmsd_pkg::FLG_TC) begin
         if (op == dmsd_pkg::OP_SET_FLAG) begin
            tc_r <= 1'b1;
         end else if (op == dmsd_pkg::OP_CLR_FLAG) begin
            tc_r <= 1'b0;
         end
      end
   end

   // conditional decision: taken when test flag equals the asked polarity
   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         decision_r <= 1'b0;
      end else if (cmd_go && op == dmsd_pkg::OP_COND) begin
         decision_r <= (tc_r == arg[0]);
      end
   end

   // operand, multiplier operand and auxiliary registers
   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         operand_r <= 16'h0;
         mult_op_r <= 16'h0;
         aux_sel_r <= 16'h0;
         aux_zero_r <= 16'h0;
      end else begin
         if (wr && paddr_i == dmsd_pkg::OFS_OPERAND) begin
            operand_r <= pwdata_i[15:0];
         end
         if (wr && paddr_i == dmsd_pkg::OFS_MULT_OP) begin
            mult_op_r <= pwdata_i[15:0];
         end else if (cmd_go && op == dmsd_pkg::OP_LOAD_MULT) begin
            mult_op_r <= operand_r;
         end
         if (wr && paddr_i == dmsd_pkg::OFS_AUX) begin
            aux_sel_r <= pwdata_i[15:0];
            aux_zero_r <= pwdata_i[31:16];
         end
      end
   end

   // product register: loaded in the command's own cycle, never shifted in place
   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         product_register_r <= 32'h0;
      end else if (cmd_go && (op == dmsd_pkg::OP_MPY || op == dmsd_pkg::OP_UNSIGNED_MULTIPLY_INSTRUCTION)) begin
         product_register_r <= product_w;
      end
   end

   // outputs straight from flops
   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;
   assign xf_o = xf_r;
   assign test_flag_o = tc_r;
endmodule
`default_nettype wire

// ### bench/dmsd_checker.sv
`default_nettype none
module dmsd_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // flags
   input wire logic xf_o,
   input wire logic test_flag_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   // a status read must mirror the live pins, so any stale copy shows up here
   logic rd_st;
   assign rd_st = pready_o && !pwrite_i && paddr_i == dmsd_pkg::OFS_STATUS;
   property p_ready_pulse;
      pready_o |=> !pready_o;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
   property p_ready_wait;
      $rose(psel_i && penable_i) |=> pready_o;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("pready late");
   property p_idle;
      !pready_o |-> prdata_o == 32'h0 && !pslverr_o;
   endproperty
   a_idle: assert property (p_idle) else $error("data outside answer");
   property p_unmapped;
      pready_o && paddr_i > dmsd_pkg::OFS_DECISION |-> pslverr_o && prdata_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
   property p_rst_flags;
      $rose(rstn_i) |-> xf_o && !test_flag_o;
   endproperty
   a_rst_flags: assert property (p_rst_flags) else $error("flag reset value");
   property p_xf_cause;
      $changed(xf_o) |-> $past(pready_o && pwrite_i);
   endproperty
   a_xf_cause: assert property (p_xf_cause) else $error("pin moved alone");
   property p_tc_cause;
      $changed(test_flag_o) |-> $past(pready_o && pwrite_i);
   endproperty
   a_tc_cause: assert property (p_tc_cause) else $error("test flag moved alone");
   property p_st_view;
      rd_st |-> prdata_o[dmsd_pkg::POS_XF] == xf_o && prdata_o[dmsd_pkg::POS_TC] == test_flag_o;
   endproperty
   a_st_view: assert property (p_st_view) else $error("status view differs");
   c_err: cover property (pslverr_o);
   c_xf_low: cover property ($fell(xf_o));
   c_tc_high: cover property ($rose(test_flag_o));
endmodule
bind dmsd_top dmsd_checker u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .xf_o(xf_o),
   .test_flag_o(test_flag_o));
`default_nettype wire

// ### bench/dsp_multiplier_scaling_datapath_tb.sv
`default_nettype none
module dsp_multiplier_scaling_datapath_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [3:0] op;
      logic [15:0] a;
      logic [15:0] b;
      logic [1:0] pm;
      logic [31:0] raw;
      logic [31:0] shf;
   } dmsd_row_s;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o, rv;
   logic pready_o, pslverr_o, xf_o, test_flag_o, ev;
   int fail_count = 0, checks = 0, cycles = 0;
   int pos[4] = '{dmsd_pkg::POS_SAT, dmsd_pkg::POS_SXM, dmsd_pkg::POS_TC, dmsd_pkg::POS_XF};
   // multiplier cases: operand register, operand, mode, raw and shifted product
   dmsd_row_s rows[6] = '{
      '{dmsd_pkg::OP_MPY, 16'hfffe, 16'h0003, 2'h0, 32'hfffffffa, 32'hfffffffa},
      '{dmsd_pkg::OP_MPY, 16'h8000, 16'h8000, 2'h1, 32'h40000000, 32'h80000000},
      '{dmsd_pkg::OP_MPY, 16'h1234, 16'h0010, 2'h2, 32'h00012340, 32'h00123400},
      '{dmsd_pkg::OP_MPY, 16'hff00, 16'h0100, 2'h3, 32'hffff0000, 32'hfffffc00},
      '{dmsd_pkg::OP_UNSIGNED_MULTIPLY_INSTRUCTION, 16'hffff, 16'hffff, 2'h3, 32'hfffe0001, 32'hfffff800},
      '{dmsd_pkg::OP_UNSIGNED_MULTIPLY_INSTRUCTION, 16'h8000, 16'h0002, 2'h1, 32'h00010000, 32'h00020000}};
   always #12.5 clk_i = ~clk_i;
   dmsd_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .xf_o(xf_o), .test_flag_o(test_flag_o));
   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one apb transfer; request held until the rising edge at which pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      rv = prdata_o;
      ev = pslverr_o;
      if (n >= 20) chk("pready", 32'h0, 32'h1);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task cmd(input logic [3:0] op, input logic [4:0] arg);
      wr(dmsd_pkg::OFS_CMD, {23'h0, arg, op});
   endtask
   task tc_is(input logic e);
      @(negedge clk_i);
      chk("test_flag", {31'h0, test_flag_o}, {31'h0, e});
   endtask
   // status load, accumulator preset, operand, one add, then read back
   task add_case(input logic [3:0] op, input logic [4:0] arg, input logic [31:0] st,
         input logic [31:0] acc0, input logic [15:0] opnd, input logic [31:0] exp);
      wr(dmsd_pkg::OFS_STATUS, st);
      wr(dmsd_pkg::OFS_ACC, acc0);
      wr(dmsd_pkg::OFS_OPERAND, {16'h0, opnd});
      cmd(op, arg);
      rd(dmsd_pkg::OFS_ACC);
      chk("acc", rv, exp);
   endtask
   // hang guard well above the 145 transfers below
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         test_done;
      end
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(dmsd_pkg::OFS_STATUS);
      chk("status_rst", rv & 32'h3c13, 32'h0410);
      chk("pins_rst", {30'h0, xf_o, test_flag_o}, 32'h2);
      foreach (rows[i]) begin
         wr(dmsd_pkg::OFS_OPERAND, {16'h0, rows[i].a});
         cmd(dmsd_pkg::OP_LOAD_MULT, 5'h0);
         wr(dmsd_pkg::OFS_OPERAND, {16'h0, rows[i].b});
         cmd(dmsd_pkg::OP_SET_PM, {3'h0, rows[i].pm});
         cmd(rows[i].op, 5'h0);
         rd(dmsd_pkg::OFS_MULT_OP);
         chk("mult_op", rv, {16'h0, rows[i].a});
         rd(dmsd_pkg::OFS_PROD_SHIFTED);
         chk("prod_shifted", rv, rows[i].shf);
         rd(dmsd_pkg::OFS_PROD_RAW);
         chk("prod_raw", rv, rows[i].raw);
         rd(dmsd_pkg::OFS_STATUS);
         chk("pm", {30'h0, rv[1:0]}, {30'h0, rows[i].pm});
      end
      add_case(dmsd_pkg::OP_ADD_PROD, 5'd0, 32'h1, 32'h0, 16'h0, 32'h00020000);
      for (int f = 0; f < 4; f++) begin
         cmd(dmsd_pkg::OP_CLR_FLAG, 5'(f));
         rd(dmsd_pkg::OFS_STATUS);
         chk("flag_clr", {31'h0, rv[pos[f]]}, 32'h0);
         cmd(dmsd_pkg::OP_SET_FLAG, 5'(f));
         rd(dmsd_pkg::OFS_STATUS);
         chk("flag_set", {31'h0, rv[pos[f]]}, 32'h1);
      end
      wr(dmsd_pkg::OFS_STATUS, 32'h0);
      @(negedge clk_i);
      chk("pins_load", {30'h0, xf_o, test_flag_o}, 32'h0);
      wr(dmsd_pkg::OFS_MULT_OP, 32'h3);
      add_case(dmsd_pkg::OP_ADD_SHIFT, 5'd0, 32'h400, 32'h0, 16'h8001, 32'hffff8001);
      add_case(dmsd_pkg::OP_ADD_SHIFT, 5'd16, 32'h400, 32'h0, 16'h8001, 32'h80010000);
      add_case(dmsd_pkg::OP_ADD_SHIFT, 5'd4, 32'h0, 32'h0, 16'h8001, 32'h00080010);
      add_case(dmsd_pkg::OP_ADD_NOEXT, 5'd4, 32'h400, 32'h0, 16'h8001, 32'h00080010);
      add_case(dmsd_pkg::OP_ADD_BY_MULT, 5'd0, 32'h400, 32'h0, 16'h8001, 32'hfffc0008);
      rd(dmsd_pkg::OFS_SCALED);
      chk("scaled", rv, 32'hffff8001);
      add_case(dmsd_pkg::OP_ADD_SHIFT, 5'd0, 32'h0, 32'h7fffffff, 16'h1, 32'h80000000);
      add_case(dmsd_pkg::OP_ADD_SHIFT, 5'd0, 32'h1000, 32'h7fffffff, 16'h1, 32'h7fffffff);
      add_case(dmsd_pkg::OP_ADD_SHIFT, 5'h0, 32'h1400, 32'h80000000, 16'hffff,
               32'h80000000);
      rd(dmsd_pkg::OFS_STATUS);
      chk("ovf", {31'h0, rv[dmsd_pkg::POS_OVF]}, 32'h1);
      // bit test counts from the msb; a false outcome must clear the flag
      wr(dmsd_pkg::OFS_MULT_OP, 32'h0);
      wr(dmsd_pkg::OFS_OPERAND, 32'h8000);
      cmd(dmsd_pkg::OP_BIT_TEST, 5'd0);
      tc_is(1'b1);
      wr(dmsd_pkg::OFS_MULT_OP, 32'hf);
      cmd(dmsd_pkg::OP_BIT_TEST, 5'd0);
      tc_is(1'b0);
      wr(dmsd_pkg::OFS_AUX, 32'h00050003);
      for (int c = 0; c < 4; c++) begin
         cmd(dmsd_pkg::OP_AUX_CMP, 5'(c));
         tc_is(c[0]);
      end
      wr(dmsd_pkg::OFS_ACC, 32'h40000000);
      cmd(dmsd_pkg::OP_NORMALIZE, 5'd0);
      tc_is(1'b1);
      wr(dmsd_pkg::OFS_ACC, 32'h20000000);
      cmd(dmsd_pkg::OP_NORMALIZE, 5'd0);
      tc_is(1'b0);
      for (int k = 0; k < 2; k++) begin
         cmd(dmsd_pkg::OP_COND, 5'(k));
         rd(dmsd_pkg::OFS_DECISION);
         chk("decision", rv, 32'(1 - k));
      end
      // refused and write-only places
      wr(8'h40, 32'hffffffff);
      chk("err_wr", {31'h0, ev}, 32'h1);
      rd(8'h40);
      chk("err_rd", {ev, rv[30:0]}, 32'h80000000);
      rd(dmsd_pkg::OFS_CMD);
      chk("cmd_rd", rv, 32'h0);
      // second reset in mid-run must restore the mode bits and the pin
      cmd(dmsd_pkg::OP_SET_PM, 5'd3);
      cmd(dmsd_pkg::OP_CLR_FLAG, 5'(dmsd_pkg::FLG_XF));
      cmd(dmsd_pkg::OP_SET_FLAG, 5'(dmsd_pkg::FLG_TC));
      rstn_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("pins_rst2", {30'h0, xf_o, test_flag_o}, 32'h2);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(dmsd_pkg::OFS_STATUS);
      chk("status_rst2", rv & 32'h3c13, 32'h0410);
      test_done;
   end
endmodule
`default_nettype wire
